// *** gaf_top.sv ***
// Alert pin, capacity and temperature flags, and battery detection for the fuel gauge
// Notes on behaviour
// - An 8-bit configuration word holds seven documented control fields and one reserved bit.
// - Reserve compensation bit enables no-load rate compensation; default zero.
// - Function select chooses battery-low level or interrupt pulses on the alert pin.
// - Sleep is allowed only with sleep permit set and conditions allowing; default one.
// - On charge termination with reload set, remaining capacity takes full capacity.
// - Insertion source bit picks the detection pin or host subcommands.
// - Polarity bit set makes the pin active high, clear makes it active low.
// - Host-written temperature used when enabled, default 25 C; else internal sensor.
// - Battery-low mode: pin follows the initial low capacity flag.
// - Initial low flag sets below 150 mAh, clears above 175 mAh.
// - Final low flag sets below 75 mAh, clears above 100 mAh once set.
// - Charging across 100 minus n steps upward gives a 1 ms pulse.
// - Discharging below 0 or 100 minus n steps gives a 1 ms pulse.
// - Every change among charge, discharge and relax gives a 1 ms pulse while the interrupt step is nonzero.
// - With pin detection, battery removal gives a 1 ms pulse.
// - Host sets detected bit; gauging runs after insertion and init, stops without battery.
// - Charge overtemp sets after 2 s at 55 C with charge current, clears at 50 C.
// - Discharge overtemp sets after 2 s at 60 C with discharge current, clears at 55 C.
// - Termination after two 40 s taper windows plus voltage check clears charging.
// - Charge inhibit above 45 C or below 0 C, cleared back inside 5 to 40 C.
//
// The address map and the plain strobed port were left to the implementer.
module gaf_top #(
  parameter int unsigned PULSE_CYC = gaf_pkg::PULSE_CYCLES,
  parameter int unsigned OT_CYC = gaf_pkg::OT_CYCLES,
  parameter int unsigned TAPER_CYC = gaf_pkg::TAPER_CYCLES
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Measurements from the gauging core
  input wire logic signed [15:0] SENSOR_TEMP,
  input wire logic signed [15:0] AVG_CURRENT,
  input wire logic [15:0] VOLTAGE,
  input wire logic [15:0] CHARGE_ACC,
  input wire logic [7:0] STATE_OF_CHARGE,
  input wire gaf_pkg::gaf_batt_e BATT_STATE,
  input wire logic [15:0] FULL_CHARGE_CAPACITY,
  input wire logic RM_LOAD,
  input wire logic [15:0] RM_IN,
  input wire logic SLEEP_CONDITIONS,
  input wire logic INIT_DONE,
  // Battery detection pin
  input wire logic DETECTION_PIN,
  // Outputs to pin and core
  output logic MULTIPLEXED_ALERT_PIN,
  output gaf_pkg::gaf_flags_s FLAGS,
  output logic [15:0] REMAINING_CAPACITY,
  output logic signed [15:0] TEMPERATURE,
  output logic RESERVE_COMP_ENABLE,
  output logic SLEEP_ALLOWED,
  output logic GAUGING_ACTIVE
);
  import gaf_pkg::*;

  typedef enum logic [1:0] {GS_NO_BATT, GS_INIT, GS_NORMAL} gaf_gauge_e;

  gaf_opcfg_s op_config;
  logic [7:0] interrupt_step;
  logic signed [15:0] host_temp;
  logic battery_detected_bit;
  logic battery_present;
  gaf_gauge_e gauge_state;
  logic pin_q;
  logic [15:0] rm_q;
  logic [7:0] soc_prev;
  gaf_batt_e batt_prev;
  logic pin_prev;
  logic [31:0] pulse_cnt;
  logic pulse_active;
  logic [31:0] otc_cnt;
  logic [31:0] otd_cnt;
  logic [31:0] win_cnt;
  logic win_cur_ok;
  logic [15:0] win_acc_start;
  logic [1:0] good_windows;
  logic term_pulse;
  logic insert_event;
  logic remove_event;
  logic soc_event;
  logic next_pin;
  logic [15:0] next_rdata;
  logic win_good;
  logic wr_ctl;

  // Any multiple of step inside [100-hi, 100-lo) marks a crossed point
  function automatic logic crossed(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] step);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] first;
    a = 8'h64 - hi;
    b = 8'h64 - lo;
    first = 8'((a + step - 8'h01) / step * step);
    return (first < b) && (hi <= 8'h64);
  endfunction

  assign wr_ctl = WR && (ADDR == REG_CONTROL);

  // Configuration registers; reserved bit is not stored
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      op_config <= OP_CONFIG_RESET;
      interrupt_step <= 8'h01;
    end else if (CE && WR) begin
      if (ADDR == REG_OP_CONFIG) begin
        op_config <= WDATA[7:0] & ~(8'h01 << OPCFG_RESERVED_BIT);
      end
      if (ADDR == REG_INT_STEP) begin
        interrupt_step <= WDATA[7:0];
      end
    end
  end

  // Host temperature only accepted while the host is the source
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      host_temp <= TEMP_DEFAULT;
      TEMPERATURE <= TEMP_DEFAULT;
    end else if (CE) begin
      if (WR && ADDR == REG_TEMPERATURE && op_config.host_temperature_enable) begin
        host_temp <= WDATA;
      end
      TEMPERATURE <= op_config.host_temperature_enable ? host_temp : SENSOR_TEMP;
    end
  end

  // Insertion and removal events from the pin or from subcommands
  always_comb begin
    if (op_config.insertion_source_pin) begin
      insert_event = pin_prev && !DETECTION_PIN;
      remove_event = !pin_prev && DETECTION_PIN;
    end else begin
      insert_event = wr_ctl && WDATA[CTL_INSERT_BIT];
      remove_event = wr_ctl && WDATA[CTL_REMOVE_BIT];
    end
  end

  // Battery presence; host set of the detected bit wins over a removal
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev <= 1'b1;
      battery_present <= 1'b0;
      battery_detected_bit <= 1'b0;
    end else if (CE) begin
      pin_prev <= DETECTION_PIN;
      if (insert_event) begin
        battery_present <= 1'b1;
      end else if (remove_event) begin
        battery_present <= 1'b0;
      end
      if (wr_ctl && WDATA[CTL_DETECTED_BIT]) begin
        battery_detected_bit <= 1'b1;
      end else if (remove_event) begin
        battery_detected_bit <= 1'b0;
      end
    end
  end

  // Gauging only runs with a present, host-confirmed battery
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gauge_state <= GS_NO_BATT;
    end else if (CE) begin
      unique case (gauge_state)
        GS_NO_BATT: begin
          if (battery_present && battery_detected_bit) begin
            gauge_state <= GS_INIT;
          end
        end
        GS_INIT: begin
          if (!battery_present) begin
            gauge_state <= GS_NO_BATT;
          end else if (INIT_DONE) begin
            gauge_state <= GS_NORMAL;
          end
        end
        GS_NORMAL: begin
          if (!battery_present) begin
            gauge_state <= GS_NO_BATT;
          end
        end
        default: gauge_state <= GS_NO_BATT;
      endcase
    end
  end

  // Core-facing outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      GAUGING_ACTIVE <= 1'b0;
      SLEEP_ALLOWED <= 1'b0;
      RESERVE_COMP_ENABLE <= 1'b0;
    end else if (CE) begin
      GAUGING_ACTIVE <= (gauge_state == GS_NORMAL) && battery_present;
      SLEEP_ALLOWED <= op_config.sleep_permit && SLEEP_CONDITIONS && (gauge_state == GS_NORMAL);
      RESERVE_COMP_ENABLE <= op_config.reserve_comp_enable;
    end
  end

  // Remaining capacity: core loads, termination reload overrides
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rm_q <= 16'h0000;
    end else if (CE) begin
      if (term_pulse && op_config.capacity_reload_enable) begin
        rm_q <= FULL_CHARGE_CAPACITY;
      end else if (RM_LOAD) begin
        rm_q <= RM_IN;
      end
    end
  end
  assign REMAINING_CAPACITY = rm_q;

  // Capacity flags with hysteresis between set and clear thresholds
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS.initial_low_capacity_flag <= 1'b0;
      FLAGS.final_low_capacity_flag <= 1'b0;
    end else if (CE) begin
      if (rm_q < INITIAL_LOW_CAPACITY_FLAG_SET_MAH) begin
        FLAGS.initial_low_capacity_flag <= 1'b1;
      end else if (rm_q > INITIAL_LOW_CAPACITY_FLAG_CLR_MAH) begin
        FLAGS.initial_low_capacity_flag <= 1'b0;
      end
      if (rm_q < FINAL_LOW_CAPACITY_FLAG_SET_MAH) begin
        FLAGS.final_low_capacity_flag <= 1'b1;
      end else if (rm_q > FINAL_LOW_CAPACITY_FLAG_CLR_MAH) begin
        FLAGS.final_low_capacity_flag <= 1'b0;
      end
    end
  end

  // Overtemperature qualification counters; any break restarts the time
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      otc_cnt <= 32'h0;
      otd_cnt <= 32'h0;
      FLAGS.charge_overtemp_flag <= 1'b0;
      FLAGS.discharge_overtemp_flag <= 1'b0;
    end else if (CE) begin
      if (BATT_STATE == ST_CHARGE && TEMPERATURE >= OTC_SET && AVG_CURRENT > CHG_CURRENT_MA) begin
        otc_cnt <= (otc_cnt < OT_CYC) ? otc_cnt + 32'h1 : otc_cnt;
      end else begin
        otc_cnt <= 32'h0;
      end
      if (otc_cnt >= OT_CYC) begin
        FLAGS.charge_overtemp_flag <= 1'b1;
      end else if (TEMPERATURE <= OTC_CLR) begin
        FLAGS.charge_overtemp_flag <= 1'b0;
      end
      if (BATT_STATE == ST_DISCHARGE && TEMPERATURE >= OTD_SET && AVG_CURRENT <= -DSG_CURRENT_MA) begin
        otd_cnt <= (otd_cnt < OT_CYC) ? otd_cnt + 32'h1 : otd_cnt;
      end else begin
        otd_cnt <= 32'h0;
      end
      if (otd_cnt >= OT_CYC) begin
        FLAGS.discharge_overtemp_flag <= 1'b1;
      end else if (TEMPERATURE <= OTD_CLR) begin
        FLAGS.discharge_overtemp_flag <= 1'b0;
      end
    end
  end

  // Charge inhibit with a narrower release window
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS.charge_inhibit_flag <= 1'b0;
    end else if (CE) begin
      if (TEMPERATURE < INH_LOW || TEMPERATURE > INH_HIGH) begin
        FLAGS.charge_inhibit_flag <= 1'b1;
      end else if (TEMPERATURE >= INH_OK_LOW && TEMPERATURE <= INH_OK_HIGH) begin
        FLAGS.charge_inhibit_flag <= 1'b0;
      end
    end
  end

  // Taper windows: current must stay low for the whole window
  assign win_good = win_cur_ok && (AVG_CURRENT < TAPER_CURRENT_MA) &&
                    (16'(CHARGE_ACC - win_acc_start) > TAPER_CHARGE_MIN);
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      win_cnt <= 32'h0;
      win_cur_ok <= 1'b1;
      win_acc_start <= 16'h0000;
      good_windows <= 2'h0;
      term_pulse <= 1'b0;
    end else if (CE) begin
      term_pulse <= 1'b0;
      if (!FLAGS.charging) begin
        win_cnt <= 32'h0;
        win_cur_ok <= 1'b1;
        win_acc_start <= CHARGE_ACC;
        good_windows <= 2'h0;
      end else if (win_cnt >= TAPER_CYC - 1) begin
        win_cnt <= 32'h0;
        win_cur_ok <= 1'b1;
        win_acc_start <= CHARGE_ACC;
        if (!win_good) begin
          good_windows <= 2'h0;
        end else if (good_windows + 2'h1 >= TAPER_WINDOWS && VOLTAGE > CHARGING_VOLTAGE_MV - TAPER_VOLTAGE_MV) begin
          good_windows <= 2'h0;
          term_pulse <= 1'b1;
        end else if (good_windows < TAPER_WINDOWS - 2'h1) begin
          good_windows <= good_windows + 2'h1;
        end
      end else begin
        win_cnt <= win_cnt + 32'h1;
        if (AVG_CURRENT >= TAPER_CURRENT_MA) begin
          win_cur_ok <= 1'b0;
        end
      end
    end
  end

  // Charging flag: termination wins over a fresh entry into charge
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS.charging <= 1'b0;
    end else if (CE) begin
      if (term_pulse) begin
        FLAGS.charging <= 1'b0;
      end else if (BATT_STATE == ST_CHARGE && batt_prev != ST_CHARGE) begin
        FLAGS.charging <= 1'b1;
      end
    end
  end

  // State-of-charge crossings and battery state changes
  always_comb begin
    soc_event = 1'b0;
    if (interrupt_step != 8'h00) begin
      if (BATT_STATE == ST_CHARGE && STATE_OF_CHARGE > soc_prev) begin
        soc_event = crossed(soc_prev, STATE_OF_CHARGE, interrupt_step);
      end
      if (BATT_STATE == ST_DISCHARGE && STATE_OF_CHARGE < soc_prev) begin
        soc_event = crossed(STATE_OF_CHARGE, soc_prev, interrupt_step);
      end
      if (BATT_STATE != batt_prev) begin
        soc_event = 1'b1;
      end
    end
    if (op_config.insertion_source_pin && !pin_prev && DETECTION_PIN) begin
      soc_event = 1'b1;
    end
  end

  // Pulse stretcher; a new event restarts the full width
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      soc_prev <= 8'h00;
      batt_prev <= ST_RELAX;
      pulse_cnt <= 32'h0;
      pulse_active <= 1'b0;
    end else if (CE) begin
      soc_prev <= STATE_OF_CHARGE;
      batt_prev <= BATT_STATE;
      if (soc_event) begin
        pulse_cnt <= PULSE_CYC - 1;
        pulse_active <= 1'b1;
      end else if (pulse_cnt != 32'h0) begin
        pulse_cnt <= pulse_cnt - 32'h1;
      end else begin
        pulse_active <= 1'b0;
      end
    end
  end

  // Alert pin: pick function, then apply polarity
  always_comb begin
    if (op_config.output_function_select) begin
      next_pin = FLAGS.initial_low_capacity_flag;
    end else begin
      next_pin = pulse_active;
    end
    next_pin = op_config.output_polarity ? next_pin : !next_pin;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_q <= 1'b1;
    end else if (CE) begin
      pin_q <= next_pin;
    end
  end
  assign MULTIPLEXED_ALERT_PIN = pin_q;

  // Read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    unique case (ADDR)
      REG_OP_CONFIG: next_rdata = {8'h00, op_config};
      REG_FLAGS: next_rdata = {10'h000, FLAGS};
      REG_CONTROL: next_rdata = {13'h0000, battery_detected_bit, 2'h0};
      REG_TEMPERATURE: next_rdata = TEMPERATURE;
      REG_INT_STEP: next_rdata = {8'h00, interrupt_step};
      REG_REM_CAP: next_rdata = rm_q;
      REG_STATUS: next_rdata = {12'h000, GAUGING_ACTIVE, gauge_state == GS_INIT, battery_present, pulse_active};
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      RDATA <= RD ? next_rdata : 16'h0000;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N || !CE);

  chk_low_set: assert property (rm_q < INITIAL_LOW_CAPACITY_FLAG_SET_MAH |=> FLAGS.initial_low_capacity_flag)
    else $error("initial low flag not set");
  chk_low_clear: assert property (rm_q > INITIAL_LOW_CAPACITY_FLAG_CLR_MAH |=> !FLAGS.initial_low_capacity_flag)
    else $error("initial low flag not cleared");
  chk_final_set: assert property (rm_q < FINAL_LOW_CAPACITY_FLAG_SET_MAH |=> FLAGS.final_low_capacity_flag)
    else $error("final low flag not set");
  chk_inhibit_hot: assert property (TEMPERATURE > INH_HIGH |=> FLAGS.charge_inhibit_flag)
    else $error("charge inhibit missing");
  chk_otc_qualified: assert property ($rose(FLAGS.charge_overtemp_flag) |-> $past(otc_cnt) >= OT_CYC)
    else $error("charge overtemp set early");
  chk_reload_fcc: assert property (term_pulse && op_config.capacity_reload_enable |=> rm_q == $past(FULL_CHARGE_CAPACITY))
    else $error("capacity not reloaded");
  sequence removal_seen;
    op_config.insertion_source_pin && !pin_prev && DETECTION_PIN;
  endsequence
  sequence pulse_held;
    pulse_active [*8];
  endsequence
  chk_removal_pulse: assert property (removal_seen |=> pulse_held)
    else $error("removal pulse missing");
  chk_sleep_gate: assert property (!op_config.sleep_permit |=> !SLEEP_ALLOWED)
    else $error("sleep allowed without permit");
  chk_no_batt_gauge: assert property (!battery_present |=> !GAUGING_ACTIVE)
    else $error("gauging without battery");
  chk_pin_follow: assert property (op_config.output_function_select ##1 op_config.output_function_select |->
    pin_q == ($past(op_config.output_polarity) ~^ $past(FLAGS.initial_low_capacity_flag)))
    else $error("alert pin not following low flag");
  chk_pin_idle: assert property (!op_config.output_function_select && !pulse_active ##1
    !op_config.output_function_select |-> pin_q == !$past(op_config.output_polarity))
    else $error("alert pin not at idle level");

endmodule // gaf_top

// *** gaf_pkg.sv ***
// Package holding register map, field layouts, thresholds and timing for the gauge alert logic
package gaf_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] REG_OP_CONFIG = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h1;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_TEMPERATURE = 4'h3;
  localparam logic [3:0] REG_INT_STEP = 4'h4;
  localparam logic [3:0] REG_REM_CAP = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;

  // Operation configuration word
  typedef struct packed {
    logic reserve_comp_enable;
    logic reserved;
    logic output_function_select;
    logic sleep_permit;
    logic capacity_reload_enable;
    logic insertion_source_pin;
    logic output_polarity;
    logic host_temperature_enable;
  } gaf_opcfg_s;
  localparam logic [7:0] OP_CONFIG_RESET = 8'h19;
  localparam int OPCFG_RESERVED_BIT = 6;

  // Status flags word
  typedef struct packed {
    logic charging;
    logic charge_inhibit_flag;
    logic discharge_overtemp_flag;
    logic charge_overtemp_flag;
    logic final_low_capacity_flag;
    logic initial_low_capacity_flag;
  } gaf_flags_s;

  // Control register bit positions (write one to act)
  localparam int CTL_INSERT_BIT = 0;
  localparam int CTL_REMOVE_BIT = 1;
  localparam int CTL_DETECTED_BIT = 2;

  // Battery state from the gauging core
  typedef enum logic [1:0] {ST_RELAX, ST_CHARGE, ST_DISCHARGE} gaf_batt_e;

  // Capacity thresholds in mAh
  localparam logic [15:0] INITIAL_LOW_CAPACITY_FLAG_SET_MAH = 16'h0096;
  localparam logic [15:0] INITIAL_LOW_CAPACITY_FLAG_CLR_MAH = 16'h00af;
  localparam logic [15:0] FINAL_LOW_CAPACITY_FLAG_SET_MAH = 16'h004b;
  localparam logic [15:0] FINAL_LOW_CAPACITY_FLAG_CLR_MAH = 16'h0064;

  // Temperatures in tenths of a degree Celsius
  localparam logic signed [15:0] TEMP_DEFAULT = 16'sh00fa;
  localparam logic signed [15:0] OTC_SET = 16'sh0226;
  localparam logic signed [15:0] OTC_CLR = 16'sh01f4;
  localparam logic signed [15:0] OTD_SET = 16'sh0258;
  localparam logic signed [15:0] OTD_CLR = 16'sh0226;
  localparam logic signed [15:0] INH_LOW = 16'sh0000;
  localparam logic signed [15:0] INH_HIGH = 16'sh01c2;
  localparam logic signed [15:0] INH_OK_LOW = 16'sh0032;
  localparam logic signed [15:0] INH_OK_HIGH = 16'sh0190;

  // Currents in mA, voltages in mV, charge in units of 10 uAh
  localparam logic signed [15:0] CHG_CURRENT_MA = 16'sh0064;
  localparam logic signed [15:0] DSG_CURRENT_MA = 16'sh0050;
  localparam logic signed [15:0] TAPER_CURRENT_MA = 16'sh0064;
  localparam logic [15:0] CHARGING_VOLTAGE_MV = 16'h1068;
  localparam logic [15:0] TAPER_VOLTAGE_MV = 16'h0064;
  localparam logic [15:0] TAPER_CHARGE_MIN = 16'h0019;
  localparam logic [1:0] TAPER_WINDOWS = 2'h2;

  // Timing: times in their own unit, counts derived from the 10 MHz clock
  localparam int CLK_HZ = 10000000;
  localparam int PULSE_TIME_US = 1000;
  localparam int OT_TIME_S = 2;
  localparam int TAPER_TIME_S = 40;
  localparam int PULSE_CYCLES = PULSE_TIME_US * (CLK_HZ / 1000000);
  localparam int OT_CYCLES = OT_TIME_S * CLK_HZ;
  localparam int TAPER_CYCLES = TAPER_TIME_S * CLK_HZ;

endpackage

// *** gaf_host.sv ***
// Host-side model that drives the battery detection pin
module gaf_host (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic insert_req,
  input wire logic remove_req,
  // Detection pin
  output logic detection_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Weak pull-up: pin idles high until a pack pulls it down
  initial detection_pin = 1'b1;
  // Insertion is a falling edge, removal a rising edge
  always @(posedge clk) begin
    if (insert_req) detection_pin <= 1'b0;
    else if (remove_req) detection_pin <= 1'b1;
  end
endmodule // gaf_host

// *** tb_gaf_top.sv ***
// Self-checking bench for the gauge alert logic
module tb_gaf_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gaf_pkg::*;
  localparam int PC = 16;
  localparam int OC = 20;
  logic mclk, rst_n, wr, rd, rm_load, slp_c, init_done, ins, rem, dpin, pin, rce, slp, gact;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rm, rm_in, d, volt, acc;
  logic [7:0] soc;
  logic signed [15:0] s_temp, cur, temp_o;
  gaf_batt_e bst;
  gaf_flags_s flags;
  int n_mismatch, check_count, cyc;
  gaf_host u_host (.clk(mclk), .insert_req(ins), .remove_req(rem), .detection_pin(dpin));
  gaf_top #(.PULSE_CYC(PC), .OT_CYC(OC), .TAPER_CYC(32)) u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SENSOR_TEMP(s_temp), .AVG_CURRENT(cur),
    .VOLTAGE(volt), .CHARGE_ACC(acc), .STATE_OF_CHARGE(soc), .BATT_STATE(bst),
    .FULL_CHARGE_CAPACITY(16'h053c), .RM_LOAD(rm_load), .RM_IN(rm_in), .SLEEP_CONDITIONS(slp_c),
    .INIT_DONE(init_done), .DETECTION_PIN(dpin), .MULTIPLEXED_ALERT_PIN(pin), .FLAGS(flags),
    .REMAINING_CAPACITY(rm), .TEMPERATURE(temp_o), .RESERVE_COMP_ENABLE(rce), .SLEEP_ALLOWED(slp),
    .GAUGING_ACTIVE(gact));
  // Clock at 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Charge counter climbs steadily so every taper window sees enough charge
  always @(posedge mclk) acc <= acc + 16'h0001;
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One-cycle strobe: 2 loads capacity, 1 inserts, 0 removes
  task automatic pulse(input int k);
    @(posedge mclk);
    {rm_load, ins, rem} <= 3'(1 << k);
    @(posedge mclk);
    {rm_load, ins, rem} <= 3'h0;
  endtask
  task automatic rm_set(input logic [15:0] v);
    rm_in <= v;
    pulse(2);
    idle(3);
  endtask
  task automatic t_config();
    reg_rd(REG_OP_CONFIG);
    chk("opcfg", d, 16'h0019);
    chk("sleep", {15'h0, slp}, 16'h0000);
    reg_wr(REG_OP_CONFIG, 16'h00ef);
    reg_rd(REG_OP_CONFIG);
    chk("opcfg_rsvd", d, 16'h00af);
    chk("reserve_comp_enable", {15'h0, rce}, 16'h0001);
    chk("sleep_off", {15'h0, slp}, 16'h0000);
    reg_rd(4'hf);
    chk("unmapped", d, 16'h0000);
    reg_wr(REG_OP_CONFIG, 16'h0019);
    slp_c <= 1'b0;
    idle(3);
    chk("sleep_cond", {15'h0, slp}, 16'h0000);
  endtask
  task automatic t_temp();
    chk("temp_dflt", temp_o, TEMP_DEFAULT);
    reg_wr(REG_TEMPERATURE, 16'h012c);
    idle(2);
    chk("temp_host", temp_o, 16'h012c);
    reg_wr(REG_OP_CONFIG, 16'h0018);
    idle(3);
    chk("temp_sensor", temp_o, s_temp);
    reg_wr(REG_OP_CONFIG, 16'h0019);
  endtask
  // Hysteresis walk: both flags set low, clear only above their upper thresholds
  task automatic t_lowcap();
    logic [15:0] v[5] = '{16'h0032, 16'h005a, 16'h0065, 16'h00a0, 16'h00b0};
    logic [1:0] e[5] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h0};
    for (int i = 0; i < 5; i++) begin
      rm_set(v[i]);
      chk("low_flags", {14'h0, flags.final_low_capacity_flag, flags.initial_low_capacity_flag}, e[i]);
    end
  endtask
  task automatic t_batlow();
    reg_wr(REG_OP_CONFIG, 16'h003b);
    rm_set(16'h0032);
    chk("batlow_hi", pin, 1'b1);
    reg_wr(REG_OP_CONFIG, 16'h0039);
    idle(3);
    chk("batlow_lo", pin, 1'b0);
    rm_set(16'h00c8);
    chk("batlow_idle", pin, 1'b1);
    reg_wr(REG_OP_CONFIG, 16'h0019);
  endtask
  // Each state change gives one pulse of about PC cycles on the low-active pin; with step zero a change gives none
  task automatic t_state();
    gaf_batt_e s[3] = '{ST_CHARGE, ST_DISCHARGE, ST_RELAX};
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      bst <= s[i];
      idle(4);
      chk("state_pulse", pin, 1'b0);
      n = 4;
      while (pin === 1'b0 && n < 100) begin
        idle(1);
        n++;
      end
      chk("pulse_width", (n >= PC && n <= PC + 6), 1'b1);
    end
    reg_wr(REG_INT_STEP, 16'h0000);
    @(posedge mclk);
    bst <= ST_CHARGE;
    repeat (8) begin
      idle(1);
      chk("step_zero", pin, 1'b1);
    end
  endtask
  // Low-active pin pulses only when a step point is crossed
  task automatic soc_step(input logic [7:0] v, input logic act);
    @(posedge mclk);
    soc <= v;
    idle(3);
    chk("soc_pulse", pin, !act);
    idle(20);
  endtask
  task automatic t_soc();
    reg_wr(REG_INT_STEP, 16'h000a);
    soc_step(8'h3b, 1'b0);
    soc_step(8'h3c, 1'b1);
    @(posedge mclk);
    bst <= ST_DISCHARGE;
    idle(25);
    soc_step(8'h3b, 1'b1);
    soc_step(8'h33, 1'b0);
    @(posedge mclk);
    bst <= ST_CHARGE;
    idle(25);
  endtask
  // Low current and high voltage over two windows end the charge
  task automatic t_term();
    rm_set(16'h0032);
    chk("chg_on", flags.charging, 1'b1);
    cur <= 16'sh0000;
    volt <= 16'h1040;
    idle(110);
    chk("chg_done", flags.charging, 1'b0);
    chk("rm_reload", rm, 16'h053c);
  endtask
  task automatic t_overtemp();
    cur <= 16'sh00c8;
    reg_wr(REG_TEMPERATURE, 16'h0230);
    idle(10);
    chk("otc_early", flags.charge_overtemp_flag, 1'b0);
    idle(OC);
    chk("otc_set", flags.charge_overtemp_flag, 1'b1);
    chk("inh_set", flags.charge_inhibit_flag, 1'b1);
    reg_wr(REG_TEMPERATURE, 16'h01a4);
    idle(3);
    chk("otc_clr", flags.charge_overtemp_flag, 1'b0);
    chk("inh_hold", flags.charge_inhibit_flag, 1'b1);
    reg_wr(REG_TEMPERATURE, 16'h012c);
    idle(3);
    chk("inh_clr", flags.charge_inhibit_flag, 1'b0);
  endtask
  task automatic t_detect();
    reg_wr(REG_OP_CONFIG, 16'h001d);
    reg_wr(REG_CONTROL, 16'h0001);
    reg_rd(REG_STATUS);
    chk("sub_ignored", d[1], 1'b0);
    pulse(1);
    idle(3);
    reg_rd(REG_STATUS);
    chk("pin_insert", d[1], 1'b1);
    reg_wr(REG_CONTROL, 16'h0004);
    init_done <= 1'b1;
    slp_c <= 1'b1;
    idle(5);
    chk("gauging", gact, 1'b1);
    chk("sleep_on", {15'h0, slp}, 16'h0001);
    init_done <= 1'b0;
    pulse(0);
    idle(5);
    chk("remove_pulse", pin, 1'b0);
    chk("gauge_stop", gact, 1'b0);
    idle(30);
    reg_wr(REG_OP_CONFIG, 16'h0019);
    reg_wr(REG_CONTROL, 16'h0001);
    reg_rd(REG_STATUS);
    chk("sub_insert", d[1], 1'b1);
    reg_wr(REG_CONTROL, 16'h0002);
    reg_rd(REG_STATUS);
    chk("sub_remove", d[1], 1'b0);
  endtask
  initial begin
    {rst_n, wr, rd, rm_load, init_done, ins, rem, addr, wdata, rm_in, cur, acc} = '0;
    slp_c = 1'b1;
    volt = 16'h1000;
    soc = 8'h32;
    s_temp = 16'sh0064;
    bst = ST_RELAX;
    idle(2);
    rst_n <= 1'b1;
    t_config();
    t_temp();
    t_lowcap();
    t_batlow();
    t_state();
    t_soc();
    t_overtemp();
    t_term();
    t_detect();
    summarize();
  end
endmodule // tb_gaf_top
